// >>> design/crxm_pkg.sv
// Constants for the receive mask selection and buffer status block
package crxm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int STD_W = 11;
  localparam int EXT_W = 18;
  localparam int SEL_W = 2;
  localparam int NUM_FILT = 8;
  localparam int FIRST_FILT = 8;
  localparam int NUM_MASK = 3;
  localparam int NUM_BUF = 32;
  localparam int BUF_IDX_W = 5;
  localparam int INT_W = 2;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MSID0 = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_MEID0 = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_FULL_LO = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_FULL_HI = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_OVF_LO = 4'hA;
  localparam logic [ADDR_W-1:0] OFF_OVF_HI = 4'hB;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 4'hC;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 4'hD;
  // Mask standard word fields
  localparam int SID_LSB = 5;
  localparam int TYPE_BIT = 3;
  localparam int EXT_HI_LSB = 0;
  localparam int EXT_HI_W = 2;
  // Selector encodings
  localparam logic [SEL_W-1:0] SEL_MASK0 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_MASK1 = 2'h1;
  localparam logic [SEL_W-1:0] SEL_MASK2 = 2'h2;
  localparam logic [SEL_W-1:0] SEL_RSVD = 2'h3;
  // Interrupt status bits
  localparam int INT_RX_BIT = 0;
  localparam int INT_OVF_BIT = 1;
  // Reset values
  localparam logic [DATA_W-1:0] RST_SEL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_FLAGS = 16'h0000;
  localparam logic [STD_W-1:0] RST_MASK_STD = 11'h000;
  localparam logic [EXT_W-1:0] RST_MASK_EXT = 18'h00000;
  localparam logic [INT_W-1:0] RST_INT = 2'h0;
endpackage : crxm_pkg

// >>> design/crxm_match_if.sv
// Mask, filter and message signals handed to one filter comparator
`timescale 1ns/1ps
`default_nettype none
interface crxm_match_if;
  logic sel_ok;
  logic [crxm_pkg::STD_W-1:0] mask_std;
  logic [crxm_pkg::EXT_W-1:0] mask_ext;
  logic type_en;
  logic [crxm_pkg::STD_W-1:0] filt_std;
  logic [crxm_pkg::EXT_W-1:0] filt_ext;
  logic filt_ext_sel;
  logic [crxm_pkg::STD_W-1:0] msg_std;
  logic [crxm_pkg::EXT_W-1:0] msg_ext;
  logic msg_is_ext;
  logic hit;
  modport requester (
    output sel_ok, mask_std, mask_ext, type_en, filt_std, filt_ext, filt_ext_sel,
    output msg_std, msg_ext, msg_is_ext,
    input hit
  );
  modport matcher (
    input sel_ok, mask_std, mask_ext, type_en, filt_std, filt_ext, filt_ext_sel,
    input msg_std, msg_ext, msg_is_ext,
    output hit
  );
endinterface : crxm_match_if
`default_nettype wire

// >>> design/crxm_filter_match.sv
// One acceptance filter comparator under its selected mask
`timescale 1ns/1ps
`default_nettype none
module crxm_filter_match (
  crxm_match_if.matcher m
);
  logic std_ok;
  logic ext_ok;
  logic type_ok;
  // Masked bits must equal filter bits, unmasked are don't-care
  assign std_ok = ((m.msg_std ^ m.filt_std) & m.mask_std) == '0;
  assign ext_ok = ((m.msg_ext ^ m.filt_ext) & m.mask_ext) == '0;
  assign type_ok = !m.type_en || (m.msg_is_ext == m.filt_ext_sel);
  // Standard frames carry no extended bits, so only the standard part counts
  assign m.hit = m.sel_ok && type_ok && std_ok && (!m.msg_is_ext || ext_ok);
endmodule : crxm_filter_match
`default_nettype wire

// >>> design/crxm_rx_top.sv
// Receive mask selection, mask sets and buffer full/overflow status
`timescale 1ns/1ps
`default_nettype none
module crxm_rx_top #(
  parameter int NUM_FILT = crxm_pkg::NUM_FILT,
  parameter int NUM_BUF = crxm_pkg::NUM_BUF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [crxm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [crxm_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [crxm_pkg::DATA_W-1:0] rdata_o,
  // Received identifier to filter
  input wire logic msg_valid_i,
  input wire logic [crxm_pkg::STD_W-1:0] msg_std_i,
  input wire logic [crxm_pkg::EXT_W-1:0] msg_ext_i,
  input wire logic msg_is_ext_i,
  // Filter values for filters 8 to 15
  input wire logic [NUM_FILT-1:0][crxm_pkg::STD_W-1:0] filt_std_i,
  input wire logic [NUM_FILT-1:0][crxm_pkg::EXT_W-1:0] filt_ext_i,
  input wire logic [NUM_FILT-1:0] filter_extended_select_i,
  // Filter results
  output logic [NUM_FILT-1:0] hit_o,
  output logic hit_valid_o,
  // Buffer write events
  input wire logic buf_wr_i,
  input wire logic [crxm_pkg::BUF_IDX_W-1:0] buf_idx_i,
  // Status
  output logic [NUM_BUF-1:0] rx_buffer_full_flag_o,
  output logic irq_o
);
  initial begin
    if (NUM_FILT != crxm_pkg::NUM_FILT || NUM_BUF != crxm_pkg::NUM_BUF) begin
      $error("crxm_rx_top: register layout serves only 8 filters and 32 buffers");
    end
  end

  localparam int DW = crxm_pkg::DATA_W;
  localparam int HALF = NUM_BUF / 2;

  logic [DW-1:0] filter_upper_mask_source_select_reg;
  logic [crxm_pkg::STD_W-1:0] mask_std_reg [crxm_pkg::NUM_MASK];
  logic [crxm_pkg::EXT_W-1:0] mask_ext_reg [crxm_pkg::NUM_MASK];
  logic [crxm_pkg::NUM_MASK-1:0] id_type_match_enable_reg;
  logic [NUM_BUF-1:0] full_reg;
  logic [NUM_BUF-1:0] ovf_reg;
  logic [NUM_BUF-1:0] full_next;
  logic [NUM_BUF-1:0] ovf_next;
  logic [NUM_BUF-1:0] full_set;
  logic [NUM_BUF-1:0] ovf_set;
  logic [NUM_BUF-1:0] full_keep;
  logic [NUM_BUF-1:0] ovf_keep;
  logic [crxm_pkg::INT_W-1:0] int_stat_reg;
  logic [crxm_pkg::INT_W-1:0] int_mask_reg;
  logic [crxm_pkg::INT_W-1:0] int_set;
  logic [NUM_FILT-1:0] hit_vec;
  logic [NUM_FILT-1:0] hit_reg;
  logic hit_valid_reg;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rd_mux;
  logic irq_reg;

  // Mask selector register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filter_upper_mask_source_select_reg <= crxm_pkg::RST_SEL;
    end else if (wr_i && addr_i == crxm_pkg::OFF_SEL) begin
      filter_upper_mask_source_select_reg <= wdata_i;
    end
  end

  // Mask sets; cleared at reset for a defined start, software must still load them
  genvar gm;
  generate
    for (gm = 0; gm < crxm_pkg::NUM_MASK; gm++) begin : g_mask
      localparam logic [crxm_pkg::ADDR_W-1:0] SID_OFF = crxm_pkg::ADDR_W'(crxm_pkg::OFF_MSID0 + gm);
      localparam logic [crxm_pkg::ADDR_W-1:0] EID_OFF = crxm_pkg::ADDR_W'(crxm_pkg::OFF_MEID0 + gm);
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          mask_std_reg[gm] <= crxm_pkg::RST_MASK_STD;
          mask_ext_reg[gm] <= crxm_pkg::RST_MASK_EXT;
          id_type_match_enable_reg[gm] <= 1'b0;
        end else if (wr_i && addr_i == SID_OFF) begin
          mask_std_reg[gm] <= wdata_i[crxm_pkg::SID_LSB +: crxm_pkg::STD_W];
          mask_ext_reg[gm][crxm_pkg::EXT_W-1 -: crxm_pkg::EXT_HI_W] <=
            wdata_i[crxm_pkg::EXT_HI_LSB +: crxm_pkg::EXT_HI_W];
          id_type_match_enable_reg[gm] <= wdata_i[crxm_pkg::TYPE_BIT];
        end else if (wr_i && addr_i == EID_OFF) begin
          mask_ext_reg[gm][DW-1:0] <= wdata_i;
        end
      end
    end
  endgenerate

  // Per filter: pick the mask set and compare
  genvar gf;
  generate
    for (gf = 0; gf < NUM_FILT; gf++) begin : g_filt
      crxm_match_if mif ();
      logic [crxm_pkg::SEL_W-1:0] sel;
      assign sel = filter_upper_mask_source_select_reg[gf*crxm_pkg::SEL_W +: crxm_pkg::SEL_W];
      always_comb begin
        mif.sel_ok = 1'b1;
        mif.mask_std = mask_std_reg[0];
        mif.mask_ext = mask_ext_reg[0];
        mif.type_en = id_type_match_enable_reg[0];
        case (sel)
          crxm_pkg::SEL_MASK0: begin
            mif.mask_std = mask_std_reg[0];
          end
          crxm_pkg::SEL_MASK1: begin
            mif.mask_std = mask_std_reg[1];
            mif.mask_ext = mask_ext_reg[1];
            mif.type_en = id_type_match_enable_reg[1];
          end
          crxm_pkg::SEL_MASK2: begin
            mif.mask_std = mask_std_reg[2];
            mif.mask_ext = mask_ext_reg[2];
            mif.type_en = id_type_match_enable_reg[2];
          end
          default: begin
            // Reserved code can never accept a frame
            mif.sel_ok = 1'b0;
          end
        endcase
      end
      assign mif.filt_std = filt_std_i[gf];
      assign mif.filt_ext = filt_ext_i[gf];
      assign mif.filt_ext_sel = filter_extended_select_i[gf];
      assign mif.msg_std = msg_std_i;
      assign mif.msg_ext = msg_ext_i;
      assign mif.msg_is_ext = msg_is_ext_i;
      assign hit_vec[gf] = mif.hit;
      crxm_filter_match u_match (
        .m(mif.matcher)
      );
    end
  endgenerate

  // Filter results held until the next identifier
  // A stable hit vector lets software read the answer late without racing the next frame
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hit_reg <= '0;
      hit_valid_reg <= 1'b0;
    end else begin
      hit_valid_reg <= msg_valid_i;
      if (msg_valid_i) begin
        hit_reg <= hit_vec;
      end
    end
  end

  // Buffer flags: module sets, software clears by writing zero
  always_comb begin
    full_set = '0;
    ovf_set = '0;
    full_keep = '1;
    ovf_keep = '1;
    if (buf_wr_i) begin
      full_set[buf_idx_i] = 1'b1;
      ovf_set[buf_idx_i] = full_reg[buf_idx_i];
    end
    if (wr_i && addr_i == crxm_pkg::OFF_FULL_LO) begin
      full_keep[HALF-1:0] = wdata_i;
    end else if (wr_i && addr_i == crxm_pkg::OFF_FULL_HI) begin
      full_keep[NUM_BUF-1:HALF] = wdata_i;
    end else if (wr_i && addr_i == crxm_pkg::OFF_OVF_LO) begin
      ovf_keep[HALF-1:0] = wdata_i;
    end else if (wr_i && addr_i == crxm_pkg::OFF_OVF_HI) begin
      ovf_keep[NUM_BUF-1:HALF] = wdata_i;
    end
    // Set wins so a message landing during a clear is never lost
    full_next = (full_reg & full_keep) | full_set;
    ovf_next = (ovf_reg & ovf_keep) | ovf_set;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      full_reg <= '0;
      ovf_reg <= '0;
    end else begin
      full_reg <= full_next;
      ovf_reg <= ovf_next;
    end
  end

  // Interrupt status, write one to clear, set wins
  always_comb begin
    int_set = '0;
    int_set[crxm_pkg::INT_RX_BIT] = buf_wr_i;
    int_set[crxm_pkg::INT_OVF_BIT] = |ovf_set;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_stat_reg <= crxm_pkg::RST_INT;
      int_mask_reg <= crxm_pkg::RST_INT;
    end else begin
      if (wr_i && addr_i == crxm_pkg::OFF_INT_STAT) begin
        int_stat_reg <= (int_stat_reg & ~wdata_i[crxm_pkg::INT_W-1:0]) | int_set;
      end else begin
        int_stat_reg <= int_stat_reg | int_set;
      end
      if (wr_i && addr_i == crxm_pkg::OFF_INT_MASK) begin
        int_mask_reg <= wdata_i[crxm_pkg::INT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_stat_next_f(int_stat_reg, int_set) & int_mask_next_f(int_mask_reg));
    end
  end

  // Irq follows the status and mask in the same cycle they change
  // Look-ahead keeps irq a flop output yet in step with the status it reflects
  function automatic logic [crxm_pkg::INT_W-1:0] int_stat_next_f(
    input logic [crxm_pkg::INT_W-1:0] cur,
    input logic [crxm_pkg::INT_W-1:0] set
  );
    logic [crxm_pkg::INT_W-1:0] clr;
    clr = (wr_i && addr_i == crxm_pkg::OFF_INT_STAT) ? wdata_i[crxm_pkg::INT_W-1:0] : '0;
    return (cur & ~clr) | set;
  endfunction : int_stat_next_f

  function automatic logic [crxm_pkg::INT_W-1:0] int_mask_next_f(
    input logic [crxm_pkg::INT_W-1:0] cur
  );
    return (wr_i && addr_i == crxm_pkg::OFF_INT_MASK) ? wdata_i[crxm_pkg::INT_W-1:0] : cur;
  endfunction : int_mask_next_f

  // Read mux
  // Unmapped words read zero: 4'hE and 4'hF fall through every branch, 4'h7 matches no mask set in its range
  always_comb begin
    rd_mux = '0;
    if (addr_i == crxm_pkg::OFF_SEL) begin
      rd_mux = filter_upper_mask_source_select_reg;
    end else if (addr_i >= crxm_pkg::OFF_MSID0 && addr_i < crxm_pkg::OFF_MEID0) begin
      for (int i = 0; i < crxm_pkg::NUM_MASK; i++) begin
        if (addr_i == crxm_pkg::ADDR_W'(crxm_pkg::OFF_MSID0 + i)) begin
          // Bits 4 and 2 stay zero
          rd_mux[crxm_pkg::SID_LSB +: crxm_pkg::STD_W] = mask_std_reg[i];
          rd_mux[crxm_pkg::TYPE_BIT] = id_type_match_enable_reg[i];
          rd_mux[crxm_pkg::EXT_HI_LSB +: crxm_pkg::EXT_HI_W] =
            mask_ext_reg[i][crxm_pkg::EXT_W-1 -: crxm_pkg::EXT_HI_W];
        end
      end
    end else if (addr_i >= crxm_pkg::OFF_MEID0 && addr_i < crxm_pkg::OFF_FULL_LO) begin
      for (int i = 0; i < crxm_pkg::NUM_MASK; i++) begin
        if (addr_i == crxm_pkg::ADDR_W'(crxm_pkg::OFF_MEID0 + i)) begin
          rd_mux = mask_ext_reg[i][DW-1:0];
        end
      end
    end else if (addr_i == crxm_pkg::OFF_FULL_LO) begin
      rd_mux = full_reg[HALF-1:0];
    end else if (addr_i == crxm_pkg::OFF_FULL_HI) begin
      rd_mux = full_reg[NUM_BUF-1:HALF];
    end else if (addr_i == crxm_pkg::OFF_OVF_LO) begin
      rd_mux = ovf_reg[HALF-1:0];
    end else if (addr_i == crxm_pkg::OFF_OVF_HI) begin
      rd_mux = ovf_reg[NUM_BUF-1:HALF];
    end else if (addr_i == crxm_pkg::OFF_INT_STAT) begin
      rd_mux[crxm_pkg::INT_W-1:0] = int_stat_reg;
    end else if (addr_i == crxm_pkg::OFF_INT_MASK) begin
      rd_mux[crxm_pkg::INT_W-1:0] = int_mask_reg;
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_i ? rd_mux : '0;
    end
  end

  assign rdata_o = rdata_reg;
  assign hit_o = hit_reg;
  assign hit_valid_o = hit_valid_reg;
  assign rx_buffer_full_flag_o = full_reg;
  assign irq_o = irq_reg;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [crxm_pkg::SEL_W-1:0] sel8;
  assign sel8 = filter_upper_mask_source_select_reg[crxm_pkg::SEL_W-1:0];

  sequence msg_std_all_ignored_s;
    msg_valid_i && !msg_is_ext_i && sel8 == crxm_pkg::SEL_MASK0 &&
      mask_std_reg[0] == '0 && !id_type_match_enable_reg[0];
  endsequence

  sequence buf_hit_full_s;
    buf_wr_i && full_reg[buf_idx_i];
  endsequence

  rsvd_sel_a: assert property (msg_valid_i && sel8 == crxm_pkg::SEL_RSVD |=> !hit_o[0] && hit_valid_o)
    else $error("reserved selector let filter 8 hit");
  sel_layout_a: assert property (rd_i && addr_i == crxm_pkg::OFF_SEL |=>
    rdata_o[DW-1 -: crxm_pkg::SEL_W] == $past(g_filt[NUM_FILT-1].sel))
    else $error("filter 15 selector not in top bit pair");
  std_ignore_a: assert property (msg_std_all_ignored_s |=> hit_o[0])
    else $error("fully masked standard frame missed filter 8");
  ext_compare_a: assert property (msg_valid_i && msg_is_ext_i && sel8 == crxm_pkg::SEL_MASK0 &&
    |((msg_ext_i ^ filt_ext_i[0]) & mask_ext_reg[0]) |=> !hit_o[0])
    else $error("included extended bit mismatch still hit");
  type_match_a: assert property (msg_valid_i && sel8 == crxm_pkg::SEL_MASK0 && id_type_match_enable_reg[0] &&
    msg_is_ext_i != filter_extended_select_i[0] |=> !hit_o[0])
    else $error("frame type mismatch accepted");
  rsvd_zero_a: assert property (rd_i && addr_i == crxm_pkg::OFF_MSID0 |=> !rdata_o[4] && !rdata_o[2])
    else $error("unused mask bits read nonzero");
  full_set_a: assert property (buf_wr_i |=> full_reg[$past(buf_idx_i)] ##1 full_reg[$past(buf_idx_i, 2)] ||
    $past(wr_i))
    else $error("buffer write did not set full flag");
  ovf_set_a: assert property (buf_hit_full_s |=> ovf_reg[$past(buf_idx_i)] && int_stat_reg[crxm_pkg::INT_OVF_BIT])
    else $error("write to full buffer did not set overflow");
  // Flags may only drop on a software write to their word
  ovf_sticky_a: assert property (!(wr_i && (addr_i == crxm_pkg::OFF_OVF_LO || addr_i == crxm_pkg::OFF_OVF_HI)) |=>
    (ovf_reg & $past(ovf_reg)) == $past(ovf_reg))
    else $error("overflow flag dropped without software clear");
  full_sticky_a: assert property (!(wr_i && (addr_i == crxm_pkg::OFF_FULL_LO || addr_i == crxm_pkg::OFF_FULL_HI)) |=>
    (full_reg & $past(full_reg)) == $past(full_reg))
    else $error("full flag dropped without software clear");
  hit_hold_a: assert property (!msg_valid_i |=> $stable(hit_o) && !hit_valid_o)
    else $error("filter result moved without a new identifier");
  sel_low_a: assert property (rd_i && addr_i == crxm_pkg::OFF_SEL |=> rdata_o[crxm_pkg::SEL_W-1:0] == $past(sel8))
    else $error("filter 8 selector not in bottom bit pair");
  irq_level_a: assert property (|(int_stat_reg & int_mask_reg) |-> irq_o)
    else $error("irq low with unmasked status set");
endmodule : crxm_rx_top
`default_nettype wire

// >>> tb/crxm_can_node.sv
// Remote bus node model handing received identifiers and buffer stores to the block
`timescale 1ns/1ps
`default_nettype none
module crxm_can_node (
  // Clock
  input wire logic clk_i,
  // Identifier to filter
  output logic msg_valid_o,
  output logic [crxm_pkg::STD_W-1:0] msg_std_o,
  output logic [crxm_pkg::EXT_W-1:0] msg_ext_o,
  output logic msg_is_ext_o,
  // Buffer store event
  output logic buf_wr_o,
  output logic [crxm_pkg::BUF_IDX_W-1:0] buf_idx_o
);
  initial begin
    msg_valid_o = 1'b0;
    msg_std_o = 11'h000;
    msg_ext_o = 18'h00000;
    msg_is_ext_o = 1'b0;
    buf_wr_o = 1'b0;
    buf_idx_o = 5'h00;
  end

  // Lines carry the inverse between frames so a stale identifier never passes for a match
  task automatic send(input logic [crxm_pkg::STD_W-1:0] s, input logic [crxm_pkg::EXT_W-1:0] e, input logic x);
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_std_o <= s;
    msg_ext_o <= e;
    msg_is_ext_o <= x;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_std_o <= ~s;
    msg_ext_o <= ~e;
    msg_is_ext_o <= ~x;
  endtask : send

  task automatic store(input logic [crxm_pkg::BUF_IDX_W-1:0] idx);
    @(posedge clk_i);
    buf_wr_o <= 1'b1;
    buf_idx_o <= idx;
    @(posedge clk_i);
    buf_wr_o <= 1'b0;
    buf_idx_o <= ~idx;
  endtask : store
endmodule : crxm_can_node
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the receive mask selection and buffer status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic arst_n;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic msg_valid, msg_is_ext, buf_wr, hit_valid, irq;
  logic [10:0] msg_std;
  logic [17:0] msg_ext;
  logic [4:0] buf_idx;
  logic [7:0] hit;
  logic [31:0] full;
  logic [7:0][10:0] filt_std;
  logic [7:0][17:0] filt_ext;
  logic [7:0] fxs;
  logic [15:0] sel_cfg = 16'hE4E4;
  logic [10:0] mstd [3] = '{11'h7FF, 11'h7F0, 11'h000};
  logic [17:0] mext [3] = '{18'h000F0, 18'h3FFFF, 18'h3FFFF};
  logic mtype [3] = '{1'b0, 1'b1, 1'b0};
  int errors = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  crxm_can_node u_node (.clk_i(clk), .msg_valid_o(msg_valid), .msg_std_o(msg_std), .msg_ext_o(msg_ext),
    .msg_is_ext_o(msg_is_ext), .buf_wr_o(buf_wr), .buf_idx_o(buf_idx));

  crxm_rx_top u_dut (.clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .msg_valid_i(msg_valid), .msg_std_i(msg_std), .msg_ext_i(msg_ext),
    .msg_is_ext_i(msg_is_ext), .filt_std_i(filt_std), .filt_ext_i(filt_ext),
    .filter_extended_select_i(fxs), .hit_o(hit), .hit_valid_o(hit_valid), .buf_wr_i(buf_wr),
    .buf_idx_i(buf_idx), .rx_buffer_full_flag_o(full), .irq_o(irq));

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, {16'h0000, exp}, {16'h0000, rdata});
  endtask : reg_rd

  // Reference acceptance decision worked out independently of the block
  function automatic logic [7:0] exp_hits(input logic [10:0] s, input logic [17:0] e, input logic x);
    logic [7:0] h;
    int m;
    h = 8'h00;
    for (int k = 0; k < 8; k++) begin
      m = sel_cfg[2*k +: 2];
      if (m != 3 && ((s ^ filt_std[k]) & mstd[m]) == 11'h000 && (!x || ((e ^ filt_ext[k]) & mext[m]) == 18'h00000)
          && (!mtype[m] || x == fxs[k])) begin
        h[k] = 1'b1;
      end
    end
    return h;
  endfunction : exp_hits

  task automatic t_reset();
    reg_rd(crxm_pkg::OFF_SEL, 16'h0000, "sel_reset");
    reg_rd(crxm_pkg::OFF_FULL_LO, 16'h0000, "full_lo_reset");
    reg_rd(crxm_pkg::OFF_FULL_HI, 16'h0000, "full_hi_reset");
    reg_rd(crxm_pkg::OFF_OVF_LO, 16'h0000, "ovf_lo_reset");
    reg_rd(crxm_pkg::OFF_OVF_HI, 16'h0000, "ovf_hi_reset");
    chk("full_out_reset", 32'h0, full);
  endtask : t_reset

  task automatic t_regs();
    reg_wr(crxm_pkg::OFF_SEL, sel_cfg);
    reg_rd(crxm_pkg::OFF_SEL, sel_cfg, "sel_readback");
    // Unused bits are written as ones so a leak shows up on readback
    for (int m = 0; m < 3; m++) begin
      reg_wr(crxm_pkg::OFF_MSID0 + 4'(m), {mstd[m], 1'b1, mtype[m], 1'b1, mext[m][17:16]});
      reg_wr(crxm_pkg::OFF_MEID0 + 4'(m), mext[m][15:0]);
      reg_rd(crxm_pkg::OFF_MSID0 + 4'(m), {mstd[m], 1'b0, mtype[m], 1'b0, mext[m][17:16]}, "mask_std");
      reg_rd(crxm_pkg::OFF_MEID0 + 4'(m), mext[m][15:0], "mask_ext");
    end
    reg_wr(4'hE, 16'hFFFF);
    reg_rd(4'hE, 16'h0000, "unmapped");
    reg_rd(crxm_pkg::OFF_SEL, sel_cfg, "sel_kept");
  endtask : t_regs

  // Ten identifiers under the current configuration, each judged against the reference
  task automatic run_ids();
    logic [10:0] s;
    logic [17:0] e;
    logic x;
    s = 11'h000;
    e = 18'h00000;
    x = 1'b0;
    for (int i = 0; i < 10; i++) begin
      s = 11'h123 ^ 11'(i);
      e = 18'h2ABCD ^ 18'(i << 4);
      x = i[1];
      u_node.send(s, e, x);
      #1;
      chk("hit_valid", 32'h1, {31'h0, hit_valid});
      chk("hit", {24'h0, exp_hits(s, e, x)}, {24'h0, hit});
    end
    @(posedge clk);
    #1;
    chk("hit_valid_drop", 32'h0, {31'h0, hit_valid});
    chk("hit_hold", {24'h0, exp_hits(s, e, x)}, {24'h0, hit});
  endtask : run_ids

  // New selector and mask 0 standard word; filter inputs move too so none stays fixed
  task automatic cfg_filter(input logic [15:0] sel, input logic [10:0] std0, input logic type0);
    sel_cfg = sel;
    mstd[0] = std0;
    mtype[0] = type0;
    reg_wr(crxm_pkg::OFF_SEL, sel);
    reg_wr(crxm_pkg::OFF_MSID0, {std0, 1'b0, type0, 1'b0, mext[0][17:16]});
    fxs <= ~fxs;
    for (int k = 0; k < 8; k++) begin
      filt_std[k] <= filt_std[k] ^ 11'h001;
      filt_ext[k] <= filt_ext[k] ^ 18'h00010;
    end
  endtask : cfg_filter

  task automatic t_filter();
    run_ids();
    // Filter 8 on the reserved code
    cfg_filter(16'h1B1B, 11'h7FF, 1'b0);
    run_ids();
    // Filter 8 under type match with every standard bit ignored
    cfg_filter(16'hE4E4, 11'h000, 1'b1);
    run_ids();
    cfg_filter(16'hE4E4, 11'h000, 1'b0);
    run_ids();
  endtask : t_filter

  task automatic t_flags();
    u_node.store(5'd3);
    #1;
    chk("full_out", 32'h8, full);
    u_node.store(5'd20);
    u_node.store(5'd3);
    u_node.store(5'd31);
    u_node.store(5'd31);
    reg_rd(crxm_pkg::OFF_FULL_LO, 16'h0008, "full_lo");
    reg_rd(crxm_pkg::OFF_FULL_HI, 16'h8010, "full_hi");
    reg_rd(crxm_pkg::OFF_OVF_LO, 16'h0008, "ovf_lo");
    reg_rd(crxm_pkg::OFF_OVF_HI, 16'h8000, "ovf_hi");
    reg_wr(crxm_pkg::OFF_FULL_LO, 16'hFFF7);
    reg_rd(crxm_pkg::OFF_FULL_LO, 16'h0000, "full_cleared");
    reg_rd(crxm_pkg::OFF_OVF_LO, 16'h0008, "ovf_kept");
    reg_wr(crxm_pkg::OFF_OVF_LO, 16'h0000);
    reg_rd(crxm_pkg::OFF_OVF_LO, 16'h0000, "ovf_cleared");
    u_node.store(5'd5);
    // Clear and set land on the same edge
    fork
      u_node.store(5'd5);
      reg_wr(crxm_pkg::OFF_FULL_LO, 16'hFFDF);
    join
    reg_rd(crxm_pkg::OFF_FULL_LO, 16'h0020, "set_wins");
    reg_rd(crxm_pkg::OFF_OVF_LO, 16'h0020, "ovf_again");
    chk("full_out_end", 32'h8010_0020, full);
  endtask : t_flags

  task automatic t_irq();
    chk("irq_masked", 32'h0, {31'h0, irq});
    reg_rd(crxm_pkg::OFF_INT_STAT, 16'h0003, "int_stat");
    reg_wr(crxm_pkg::OFF_INT_MASK, 16'h0002);
    @(posedge clk);
    #1;
    chk("irq_on", 32'h1, {31'h0, irq});
    reg_wr(crxm_pkg::OFF_INT_STAT, 16'h0002);
    @(posedge clk);
    #1;
    chk("irq_cleared", 32'h0, {31'h0, irq});
    u_node.store(5'd7);
    #1;
    chk("irq_rx_masked", 32'h0, {31'h0, irq});
    u_node.store(5'd7);
    #1;
    chk("irq_ovf", 32'h1, {31'h0, irq});
    reg_wr(crxm_pkg::OFF_INT_STAT, 16'h0003);
    reg_rd(crxm_pkg::OFF_INT_STAT, 16'h0000, "int_stat_clear");
    chk("irq_off", 32'h0, {31'h0, irq});
  endtask : t_irq

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    fxs = 8'h5A;
    for (int k = 0; k < 8; k++) begin
      filt_std[k] = 11'h123 ^ 11'(k);
      filt_ext[k] = 18'h2ABCD ^ 18'(k << 4);
    end
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_filter();
    t_flags();
    t_irq();
    end_of_test();
  end

  // The sequence needs a few hundred cycles; allow ample margin
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
